// ==== hic_pkg.sv ====
// Shared offsets, field layouts and reset values of the hub identity bank
package hic_pkg;
    // Byte offsets of the bank
    localparam logic [7:0] PRODUCT_ID_HIGH_OFS = 8'h03;
    localparam logic [7:0] RELEASE_NUMBER_LOW_OFS = 8'h04;
    localparam logic [7:0] RELEASE_NUMBER_HIGH_OFS = 8'h05;
    localparam logic [7:0] HUB_CONFIG_BYTE_ONE_OFS = 8'h06;
    localparam logic [7:0] HUB_CONFIG_BYTE_TWO_OFS = 8'h07;
    // Reset values
    localparam logic [7:0] PRODUCT_ID_HIGH_RST = 8'h00;
    localparam logic [7:0] RELEASE_NUMBER_LOW_RST = 8'h00;
    localparam logic [7:0] RELEASE_NUMBER_HIGH_RST = 8'h00;
    localparam logic [7:0] HUB_CONFIG_BYTE_ONE_RST = 8'h00;
    localparam logic [7:0] HUB_CONFIG_BYTE_TWO_RST = 8'h00;
    // Answer for an unmapped offset
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field positions of the first configuration byte
    localparam int CFG1_POWER_SOURCE_BIT = 7;
    localparam int CFG1_RESERVED_BIT = 6;
    localparam int CFG1_HS_INHIBIT_BIT = 5;
    // Field positions of the second configuration byte
    localparam int CFG2_DYNAMIC_BIT = 7;
    localparam int CFG2_RESERVED_BIT = 6;
    // Largest decimal digit in a nibble
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

    // First configuration byte, MSB first
    typedef struct packed {
        logic powerSourceSelect;
        logic reserved;
        logic highSpeedInhibit;
        logic [4:0] otherBits;
    } hic_cfg1_s;

    // Second configuration byte, MSB first
    typedef struct packed {
        logic dynamicPower;
        logic reserved;
        logic [5:0] otherBits;
    } hic_cfg2_s;

    // One byte access from the serial engine or the loader
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hic_access_s;
endpackage

// ==== hic_sync.sv ====
// Two flip-flop level synchroniser for a pin input
module hic_sync (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pinIn,
    output logic levelOut
);
    logic stageOne; // First stage, read only by the second

    // Resolve metastability before any logic looks at the pin
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stageOne <= 1'b0;
            levelOut <= 1'b0;
        end else begin
            stageOne <= pinIn;
            levelOut <= stageOne;
        end
    end
endmodule // hic_sync

// ==== hic_regs.sv ====
// Hub identity and attach configuration byte registers
//
// Contract
// - Product identifier upper byte held at 03h
// - Release number treated as BCD digits
// - Release low byte 04h, high 05h
// - Loaded by serial host or configuration memory
// - Power select: 0 bus, 1 self powered
// - Dynamic switching uses supply pin instead
// - High speed inhibit forces full speed attach
// - Reserved configuration bit always reads zero
// - First configuration byte resets to 00h
// - Dynamic switching enabled by byte two bit7
module hic_regs #(
    // Low product byte lives in the neighbouring bank; plain default here
    parameter logic [7:0] PRODUCT_ID_LOW = 8'h00
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire hic_pkg::hic_access_s hostAccess,
    input wire logic loadWrite,
    input wire hic_pkg::hic_access_s loadAccess,
    input wire logic localSupplyPresent,
    output logic [7:0] hostRdData,
    output logic hostRdValid,
    output logic [15:0] productIdBits,
    output logic [15:0] releaseNumber,
    output logic releaseIsBcd,
    output logic selfPowered,
    output logic fullSpeedOnly,
    output logic powerSourceChange
);
    // Reserved bit masks, cleared on every write so they read back zero
    localparam logic [7:0] CFG1_RSV_MASK =
        8'h01 << hic_pkg::CFG1_RESERVED_BIT;
    localparam logic [7:0] CFG2_RSV_MASK =
        8'h01 << hic_pkg::CFG2_RESERVED_BIT;

    // Stored bytes of the bank
    logic [7:0] productIdHigh; // Upper product identifier byte
    logic [7:0] releaseLow; // Release number, two low digits
    logic [7:0] releaseHigh; // Release number, two high digits
    hic_pkg::hic_cfg1_s cfg1Reg; // First configuration byte
    hic_pkg::hic_cfg2_s cfg2Reg; // Second configuration byte

    // Write path
    logic wrEn; // Some writer is active this cycle
    hic_pkg::hic_access_s wrAccess; // Access that wins this cycle
    logic hitPidHigh; // Write aimed at the product byte
    logic hitRelLow; // Write aimed at the low release byte
    logic hitRelHigh; // Write aimed at the high release byte
    logic hitCfg1; // Write aimed at the first configuration byte
    logic hitCfg2; // Write aimed at the second configuration byte
    hic_pkg::hic_cfg1_s cfg1WrData; // Write data with reserved bit cleared
    hic_pkg::hic_cfg2_s cfg2WrData; // Write data with reserved bit cleared

    // Read path
    logic rdPidHigh; // Read of the product byte
    logic rdRelLow; // Read of the low release byte
    logic rdRelHigh; // Read of the high release byte
    logic rdCfg1; // Read of the first configuration byte
    logic rdCfg2; // Read of the second configuration byte
    logic [7:0] readByte; // Selected byte for the host

    // Attach status
    logic supplyLevel; // Supply pin after two flip-flops
    logic next_selfPowered; // Power source the hub should report
    logic next_releaseIsBcd; // All four release digits are decimal

    // Offset match, shared by the write and read decoders
    function automatic logic addrIs(
        logic [7:0] addr,
        logic [7:0] ofs
    );
        return addr == ofs;
    endfunction

    // One nibble holds a decimal digit
    function automatic logic bcdDigitOk(logic [3:0] digit);
        return digit <= hic_pkg::BCD_MAX_DIGIT;
    endfunction

    // Host access wins over the memory loader in a shared cycle;
    // the loader only runs at start-up, so the loss is harmless
    assign wrEn = hostWrite | loadWrite;
    assign wrAccess = hostWrite ? hostAccess : loadAccess;

    // Write decode
    assign hitPidHigh = wrEn &&
        addrIs(wrAccess.addr, hic_pkg::PRODUCT_ID_HIGH_OFS);
    assign hitRelLow = wrEn &&
        addrIs(wrAccess.addr, hic_pkg::RELEASE_NUMBER_LOW_OFS);
    assign hitRelHigh = wrEn &&
        addrIs(wrAccess.addr, hic_pkg::RELEASE_NUMBER_HIGH_OFS);
    assign hitCfg1 = wrEn &&
        addrIs(wrAccess.addr, hic_pkg::HUB_CONFIG_BYTE_ONE_OFS);
    assign hitCfg2 = wrEn &&
        addrIs(wrAccess.addr, hic_pkg::HUB_CONFIG_BYTE_TWO_OFS);

    // Reserved bits are never stored
    assign cfg1WrData = hic_pkg::hic_cfg1_s'(wrAccess.data & ~CFG1_RSV_MASK);
    assign cfg2WrData = hic_pkg::hic_cfg2_s'(wrAccess.data & ~CFG2_RSV_MASK);

    // Read decode
    assign rdPidHigh = addrIs(hostAccess.addr, hic_pkg::PRODUCT_ID_HIGH_OFS);
    assign rdRelLow =
        addrIs(hostAccess.addr, hic_pkg::RELEASE_NUMBER_LOW_OFS);
    assign rdRelHigh =
        addrIs(hostAccess.addr, hic_pkg::RELEASE_NUMBER_HIGH_OFS);
    assign rdCfg1 =
        addrIs(hostAccess.addr, hic_pkg::HUB_CONFIG_BYTE_ONE_OFS);
    assign rdCfg2 =
        addrIs(hostAccess.addr, hic_pkg::HUB_CONFIG_BYTE_TWO_OFS);

    // Read selection; unmapped offsets answer a fixed byte
    assign readByte =
        rdPidHigh ? productIdHigh :
        rdRelLow ? releaseLow :
        rdRelHigh ? releaseHigh :
        rdCfg1 ? cfg1Reg :
        rdCfg2 ? cfg2Reg :
        hic_pkg::UNMAPPED_READ;

    // Supply pin is asynchronous to mclk
    hic_sync i_hic_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(localSupplyPresent),
        .levelOut(supplyLevel)
    );

    // Dynamic switching overrides the select bit with the pin
    assign next_selfPowered = cfg2Reg.dynamicPower ?
        supplyLevel :
        cfg1Reg.powerSourceSelect;

    // Release number check, digit by digit
    assign next_releaseIsBcd = bcdDigitOk(releaseLow[3:0]) &&
        bcdDigitOk(releaseLow[7:4]) &&
        bcdDigitOk(releaseHigh[3:0]) &&
        bcdDigitOk(releaseHigh[7:4]);

    // Product identifier upper byte
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            productIdHigh <= hic_pkg::PRODUCT_ID_HIGH_RST;
        end else if (hitPidHigh) begin
            productIdHigh <= wrAccess.data;
        end
    end

    // Release number low byte
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            releaseLow <= hic_pkg::RELEASE_NUMBER_LOW_RST;
        end else if (hitRelLow) begin
            releaseLow <= wrAccess.data;
        end
    end

    // Release number high byte
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            releaseHigh <= hic_pkg::RELEASE_NUMBER_HIGH_RST;
        end else if (hitRelHigh) begin
            releaseHigh <= wrAccess.data;
        end
    end

    // First configuration byte
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg1Reg <= hic_pkg::HUB_CONFIG_BYTE_ONE_RST;
        end else if (hitCfg1) begin
            cfg1Reg <= cfg1WrData;
        end
    end

    // Second configuration byte, kept for the dynamic bit
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg2Reg <= hic_pkg::HUB_CONFIG_BYTE_TWO_RST;
        end else if (hitCfg2) begin
            cfg2Reg <= cfg2WrData;
        end
    end

    // Read answer, one cycle after the request; data holds until next read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hostRdValid <= 1'b0;
            hostRdData <= 8'h00;
        end else begin
            hostRdValid <= hostRead;
            if (hostRead) begin
                hostRdData <= readByte;
            end
        end
    end

    // Identity outputs, registered so they leave straight from flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            productIdBits <= 16'h0000;
            releaseNumber <= 16'h0000;
            releaseIsBcd <= 1'b1; // Zero release is valid decimal
        end else begin
            productIdBits <= {productIdHigh, PRODUCT_ID_LOW};
            releaseNumber <= {releaseHigh, releaseLow};
            releaseIsBcd <= next_releaseIsBcd;
        end
    end

    // Attach outputs; the change pulse lets the port logic re-attach
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            selfPowered <= 1'b0;
            fullSpeedOnly <= 1'b0;
            powerSourceChange <= 1'b0;
        end else begin
            selfPowered <= next_selfPowered;
            fullSpeedOnly <= cfg1Reg.highSpeedInhibit;
            powerSourceChange <= next_selfPowered != selfPowered;
        end
    end

    // Checks run on mclk and sleep in reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Every read is answered on the next edge
    rd_answer_a: assert property (
        hostRead |=> hostRdValid && hostRdData == $past(readByte))
        else $error("read answer missing");

    // Reserved bit reads back zero
    rsv_read_zero_a: assert property (
        hostRead && rdCfg1 |=> !hostRdData[hic_pkg::CFG1_RESERVED_BIT])
        else $error("reserved bit read as one");

    // Reserved bits are never stored
    cfg_reserved_a: assert property (
        !cfg1Reg.reserved && !cfg2Reg.reserved)
        else $error("reserved bit stored");

    // Product byte write lands from either writer
    pid_write_a: assert property (
        hitPidHigh |=> productIdHigh == $past(wrAccess.data))
        else $error("product byte write lost");

    // Product identifier carries the stored upper byte
    pid_output_a: assert property (
        productIdBits == {$past(productIdHigh), PRODUCT_ID_LOW})
        else $error("product identifier wrong");

    // Release bytes in their order
    release_out_a: assert property (
        releaseNumber == {$past(releaseHigh), $past(releaseLow)})
        else $error("release number wrong");

    // Decimal flag tracks the digits
    bcd_flag_a: assert property (
        releaseIsBcd == $past(next_releaseIsBcd))
        else $error("decimal flag wrong");

    // Full speed only follows the inhibit bit
    full_speed_a: assert property (
        fullSpeedOnly == $past(cfg1Reg.highSpeedInhibit))
        else $error("speed attach wrong");

    // Reported power source follows select bit or pin
    self_power_a: assert property (
        selfPowered == $past(next_selfPowered))
        else $error("power source wrong");

    // A change of power source raises one pulse
    power_change_a: assert property (
        powerSourceChange == $past(next_selfPowered != selfPowered))
        else $error("power change pulse wrong");

    // Main scenarios
    read_seen_c: cover property (hostRdValid);
    load_seen_c: cover property (loadWrite && hitPidHigh);
    change_seen_c: cover property (powerSourceChange);
    dyn_self_c: cover property (cfg2Reg.dynamicPower && selfPowered);
endmodule // hic_regs

// ==== hic_cfg_mem.sv ====
// Serial configuration memory model that loads one identity byte
module hic_cfg_mem (
    input wire logic mclk,
    input wire logic start,
    output logic loadWrite,
    output hic_pkg::hic_access_s loadAccess
);
    // Fetch the product id high byte while started
    always @(posedge mclk) {loadWrite, loadAccess} <= {start, 16'h035A};
endmodule // hic_cfg_mem

// ==== testbench.sv ====
// Self-checking bench of the hub identity bank
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
        error_cnt++; $display("MISMATCH %0t %h %h", $time, a, b); end end
    logic mclk = 0, sys_rst = 1, hWr = 0, hRd = 0, lSup = 0, go = 0;
    logic lWr, rdV, self, fs, bcd, chg;
    int chgCnt = 0;
    logic [7:0] rd;
    logic [15:0] pid, rel;
    hic_pkg::hic_access_s hAcc = '0, lAcc;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    hic_regs i_hic_regs (.mclk, .sys_rst, .hostWrite(hWr), .hostRead(hRd),
        .hostAccess(hAcc), .loadWrite(lWr), .loadAccess(lAcc),
        .localSupplyPresent(lSup), .hostRdData(rd), .hostRdValid(rdV),
        .productIdBits(pid), .releaseNumber(rel), .releaseIsBcd(bcd),
        .selfPowered(self), .fullSpeedOnly(fs), .powerSourceChange(chg));
    // Count power change pulses
    always @(posedge mclk) if (chg === 1'b1) chgCnt++;
    hic_cfg_mem i_hic_cfg_mem (.mclk, .start(go), .loadWrite(lWr),
        .loadAccess(lAcc));
    initial forever #10 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) if (++cyc > 3000) begin
        error_cnt++;
        complete_run;
    end
    task tick(int n); repeat (n) @(posedge mclk); #1; endtask
    task wr(logic [7:0] a, d); tick(1); hWr = 1; hAcc = '{a, d}; tick(1);
        hWr = 0; endtask
    task rdc(logic [7:0] a, e); int i; tick(1); hRd = 1; hAcc.addr = a;
        tick(1); hRd = 0;
        for (i = 0; i < 8 && rdV !== 1'b1; i++) tick(1);
        `CHK(rd, e)
    endtask
    task t_reset; rdc(8'h06, 8'h00); endtask
    task t_ident; wr(8'h03, 8'h12); wr(8'h04, 8'h34); wr(8'h05, 8'h01);
        rdc(8'h03, 8'h12); rdc(8'h04, 8'h34); rdc(8'h05, 8'h01);
        `CHK(pid[15:8], 8'h12)
        `CHK(rel, 16'h0134)
        `CHK(bcd, 1'b1)
        wr(8'h05, 8'h1A); tick(2);
        `CHK(bcd, 1'b0)
    endtask
    task t_cfg; wr(8'h06, 8'hE0); rdc(8'h06, 8'hA0);
        `CHK(self, 1'b1)
        `CHK(fs, 1'b1)
        wr(8'h07, 8'h80); tick(6); `CHK(self, 1'b0)
        lSup = 1; tick(6);
        `CHK(self, 1'b1)
        `CHK(chgCnt, 3)
    endtask
    task t_load; go = 1; tick(1); go = 0; tick(3); rdc(8'h03, 8'h5A); endtask
    task complete_run;
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        tick(8); sys_rst = 0; t_reset; t_ident; t_cfg; t_load; complete_run;
    end
endmodule // testbench
